// ==== include/asr_pkg.sv ====
// constants, types and field layouts of the status and reset block
package asr_pkg;

   localparam int unsigned CLK_PERIOD_PS = 5000;

   // status bit positions
   localparam int unsigned BIT_BUSY  = 7;
   localparam int unsigned BIT_READY = 6;
   localparam int unsigned BIT_FAULT = 5;
   localparam int unsigned BIT_SEEK  = 4;
   localparam int unsigned BIT_XFER  = 3;
   localparam int unsigned BIT_FIXED = 2;
   localparam int unsigned BIT_REV   = 1;
   localparam int unsigned BIT_FAIL  = 0;

   // reset values of the task file
   localparam logic [7:0] STATUS_RESET  = 8'h50;
   localparam logic [7:0] SECCNT_RESET  = 8'h01;
   localparam logic [7:0] SECNUM_RESET  = 8'h01;
   localparam logic [7:0] CYL_LO_RESET  = 8'h00;
   localparam logic [7:0] CYL_HI_RESET  = 8'h00;
   localparam logic [7:0] DEVHEAD_RESET = 8'h00;

   // diagnostic codes
   localparam logic [7:0] DIAG_OK        = 8'h01;
   localparam logic [7:0] DIAG_FORMATTER = 8'h02;
   localparam logic [7:0] DIAG_BUFFER    = 8'h03;
   localparam logic [7:0] DIAG_ECC       = 8'h04;
   localparam logic [7:0] DIAG_CPU       = 8'h05;

   localparam logic [7:0] FEAT_REVERT_EN = 8'hcc;

   // timing
   localparam int unsigned DIAG_TIME_NS   = 10000;
   localparam int unsigned DIAG_CYCLES    = (DIAG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
   localparam int unsigned REV_MARK_NS    = 100;
   localparam int unsigned REV_MARK_CYCLES = (REV_MARK_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned REV_PERIOD_US  = 8333;
   localparam int unsigned REV_CYCLES     = (REV_PERIOD_US * 1000) / (CLK_PERIOD_PS / 1000);

   typedef enum logic [1:0] {
      SEL_STATUS,
      SEL_ALT_STATUS,
      SEL_ERROR,
      SEL_OTHER
   } asr_sel_e;

   typedef enum logic [1:0] {
      PM_ACTIVE,
      PM_IDLE,
      PM_STANDBY,
      PM_SLEEP
   } asr_pm_e;

   typedef struct packed {
      logic busy;
      logic ready;
      logic fault;
      logic seek_done;
      logic xfer_req;
      logic fixed_data;
      logic rev_mark;
      logic fail;
   } asr_status_s;

   typedef struct packed {
      logic [7:0] error;
      logic [7:0] seccnt;
      logic [7:0] secnum;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] devhead;
   } asr_tf_s;

endpackage

// ==== rtl/asr_diag.sv ====
// self-test sequencer giving the diagnostic code
`timescale 1ns/10ps
module asr_diag #(
   parameter int unsigned CYCLES = asr_pkg::DIAG_CYCLES
) (
   input  wire logic       clk,        // system clock
   input  wire logic       rst,        // synchronous reset
   input  wire logic       start,      // begin self-test
   input  wire logic [3:0] fail_in,    // formatter, buffer, ecc, cpu faults
   output logic            running,    // self-test in progress
   output logic            done,       // one-cycle end pulse
   output logic [7:0]      code        // resulting code
);
   logic [$clog2(CYCLES+1)-1:0] count;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         running <= 1'b0;
         done    <= 1'b0;
         count   <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            running <= 1'b1;
            count   <= '0;
         end
         else if (running)
         begin
            if (count == ($clog2(CYCLES+1))'(CYCLES - 1))
            begin
               running <= 1'b0;
               done    <= 1'b1;
            end
            count <= count + 1'b1;
         end
      end
   end

   // first failing stage wins
   always_ff @(posedge clk)
   begin
      if (rst)
         code <= asr_pkg::DIAG_OK;
      else if (running && count == ($clog2(CYCLES+1))'(CYCLES - 1))
      begin
         if (fail_in[0])
            code <= asr_pkg::DIAG_FORMATTER;
         else if (fail_in[1])
            code <= asr_pkg::DIAG_BUFFER;
         else if (fail_in[2])
            code <= asr_pkg::DIAG_ECC;
         else if (fail_in[3])
            code <= asr_pkg::DIAG_CPU;
         else
            code <= asr_pkg::DIAG_OK;
      end
   end
endmodule

// ==== rtl/asr_rev_mark.sv ====
// once-per-turn revolution mark from a cycle divider
`timescale 1ns/10ps
module asr_rev_mark #(
   parameter int unsigned PERIOD = asr_pkg::REV_CYCLES,
   parameter int unsigned WIDTH  = asr_pkg::REV_MARK_CYCLES
) (
   input  wire logic clk,       // system clock
   input  wire logic rst,       // synchronous reset
   input  wire logic spinning,  // spindle at speed
   output logic      mark       // short high once per turn
);
   logic [$clog2(PERIOD+1)-1:0] phase;

   always_ff @(posedge clk)
   begin
      if (rst || !spinning)
         phase <= '0;
      else if (phase == ($clog2(PERIOD+1))'(PERIOD - 1))
         phase <= '0;
      else
         phase <= phase + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         mark <= 1'b0;
      else
         mark <= spinning && (phase < ($clog2(PERIOD+1))'(WIDTH));
   end
endmodule

// ==== rtl/asr_status_reset.sv ====
// status register, interrupt pending and reset response of the drive
`timescale 1ns/10ps
module asr_status_reset #(
   parameter int unsigned REV_PERIOD  = asr_pkg::REV_CYCLES,
   parameter int unsigned DIAG_LENGTH = asr_pkg::DIAG_CYCLES
) (
   input  wire logic              clk,           // 200 MHz clock
   input  wire logic              rst,           // power-up reset, sync high
   input  wire logic              reg_rd,        // host register read strobe
   input  wire asr_pkg::asr_sel_e reg_sel,       // register being read
   output logic [7:0]             rd_data,       // read data, one cycle later
   input  wire logic              dctl_wr,       // device control write strobe
   input  wire logic              soft_reset_bit,// soft reset bit of that write
   input  wire logic              irq_mask_bit,  // interrupt mask of that write
   input  wire logic              cmd_wr,        // command register written
   input  wire logic              feat_wr,       // set-features executed
   input  wire logic [7:0]        feat_code,     // its feature code
   input  wire logic              dev_selected,  // this device addressed
   input  wire logic              reg_access,    // core is touching registers
   input  wire logic              cmd_done,      // command completion pulse
   input  wire logic              err_det,       // error detected pulse
   input  wire logic              seek_start,    // seek about to begin
   input  wire logic              seek_settled,  // head settled on track
   input  wire logic              xfer_ready,    // data word may move
   input  wire logic              pm_req,        // power mode change pulse
   input  wire asr_pkg::asr_pm_e  pm_target,     // requested mode
   input  wire logic              timer_set,     // standby timer enabled by cmd
   input  wire logic              comreset,      // link reset pulse
   input  wire logic              cache_flushed, // write cache on media
   input  wire logic              pus_enable,    // power-up in standby strap
   input  wire logic [3:0]        diag_fail,     // self-test fault inputs
   output logic                   intrq,         // interrupt to host
   output asr_pkg::asr_status_s   status,        // status register
   output asr_pkg::asr_tf_s       tf_defaults,   // task-file values to load
   output logic                   tf_load,       // load pulse for them
   output logic                   iface_reset,   // interface reset pulse
   output logic                   abort_host,    // host side abort pulse
   output logic                   abort_dev,     // device operation abort pulse
   output logic                   hw_init,       // hardware init pulse
   output logic                   param_restore, // drive parameter default pulse
   output logic                   spin_up,       // spindle spin-up request
   output logic                   stby_timer_en, // standby timer enable
   output asr_pkg::asr_pm_e       power_mode     // current power mode
);

   typedef enum logic [2:0] {
      ST_POR_START,
      ST_POR_DIAG,
      ST_RUN,
      ST_SOFT_HOLD,
      ST_FLUSH,
      ST_APPLY
   } asr_rst_e;

   asr_rst_e   state;
   asr_rst_e   next_state;
   logic       soft_rst_q;
   logic       revert_en;
   logic       irq_pending;
   logic       ready_q;
   logic       err_hold;
   logic       seek_q;
   logic       fail_q;
   logic       busy;
   logic       stat_rd;
   logic       diag_start;
   logic       diag_running;
   logic       diag_done;
   logic [7:0] diag_code;
   logic       rev_mark;
   logic       low_power;
   logic       soft_fall;

   asr_diag #(
      .CYCLES   (DIAG_LENGTH)
   ) u_diag (
      .clk      (clk),
      .rst      (rst),
      .start    (diag_start),
      .fail_in  (diag_fail),
      .running  (diag_running),
      .done     (diag_done),
      .code     (diag_code)
   );

   asr_rev_mark #(
      .PERIOD   (REV_PERIOD),
      .WIDTH    (asr_pkg::REV_MARK_CYCLES)
   ) u_rev (
      .clk      (clk),
      .rst      (rst),
      .spinning (power_mode == asr_pkg::PM_ACTIVE || power_mode == asr_pkg::PM_IDLE),
      .mark     (rev_mark)
   );

   assign diag_start = (state == ST_POR_START);
   assign low_power  = (power_mode == asr_pkg::PM_STANDBY) || (power_mode == asr_pkg::PM_SLEEP);
   assign soft_fall  = dctl_wr && soft_rst_q && !soft_reset_bit;
   assign stat_rd    = reg_rd && (reg_sel == asr_pkg::SEL_STATUS) && !busy;

   // busy covers any reset work and the core touching registers
   assign busy = (state != ST_RUN) || reg_access || comreset;

   // reset sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         ST_POR_START:
            next_state = ST_POR_DIAG;
         ST_POR_DIAG:
            if (diag_done)
               next_state = ST_RUN;
         ST_RUN:
            if (comreset)
               next_state = ST_FLUSH;
            else if (dctl_wr && soft_reset_bit)
               next_state = ST_SOFT_HOLD;
         ST_SOFT_HOLD:
            if (comreset)
               next_state = ST_FLUSH;
            else if (soft_fall)
               next_state = ST_FLUSH;
         ST_FLUSH:
            if (cache_flushed)
               next_state = ST_APPLY;
         ST_APPLY:
            next_state = ST_RUN;
         default:
            next_state = ST_POR_START;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state <= ST_POR_START;
      else
         state <= next_state;
   end

   // soft reset bit and mask as last written by the host
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         soft_rst_q <= 1'b0;
      end
      else if (dctl_wr)
      begin
         soft_rst_q <= soft_reset_bit;
      end
   end

   logic irq_mask_q;
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_mask_q <= 1'b0;
      else if (dctl_wr)
         irq_mask_q <= irq_mask_bit;
   end

   // action pulses of the reset kinds
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         iface_reset   <= 1'b0;
         abort_host    <= 1'b0;
         abort_dev     <= 1'b0;
         hw_init       <= 1'b0;
         param_restore <= 1'b0;
         tf_load       <= 1'b0;
      end
      else
      begin
         iface_reset   <= (state == ST_APPLY);
         abort_host    <= (state == ST_APPLY);
         abort_dev     <= (state == ST_APPLY);
         hw_init       <= (state == ST_POR_START);
         param_restore <= (state == ST_POR_START) || ((state == ST_APPLY) && revert_en);
         tf_load       <= (state == ST_APPLY) || diag_done;
      end
   end

   // set-features revert enable, defaults off at power-up
   always_ff @(posedge clk)
   begin
      if (rst)
         revert_en <= 1'b0;
      else if (feat_wr && feat_code == asr_pkg::FEAT_REVERT_EN)
         revert_en <= 1'b1;
   end

   // task-file defaults, error gets the diagnostic code
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tf_defaults.error   <= asr_pkg::DIAG_OK;
         tf_defaults.seccnt  <= asr_pkg::SECCNT_RESET;
         tf_defaults.secnum  <= asr_pkg::SECNUM_RESET;
         tf_defaults.cyl_lo  <= asr_pkg::CYL_LO_RESET;
         tf_defaults.cyl_hi  <= asr_pkg::CYL_HI_RESET;
         tf_defaults.devhead <= asr_pkg::DEVHEAD_RESET;
      end
      else if (diag_done)
      begin
         tf_defaults.error <= diag_code;
      end
   end

   // standby timer
   always_ff @(posedge clk)
   begin
      if (rst)
         stby_timer_en <= 1'b0;
      else if (timer_set)
         stby_timer_en <= 1'b1;
   end

   // power mode; strap sampled at the end of power-up self-test
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         power_mode <= asr_pkg::PM_STANDBY;
         spin_up    <= 1'b0;
      end
      else if (state == ST_POR_DIAG && diag_done)
      begin
         power_mode <= pus_enable ? asr_pkg::PM_STANDBY : asr_pkg::PM_IDLE;
         spin_up    <= !pus_enable;
      end
      else if (state == ST_APPLY)
      begin
         if (power_mode == asr_pkg::PM_SLEEP)
            power_mode <= asr_pkg::PM_STANDBY;
      end
      else if (pm_req && power_mode != asr_pkg::PM_SLEEP)
      begin
         power_mode <= pm_target;
         spin_up    <= (pm_target == asr_pkg::PM_ACTIVE) || (pm_target == asr_pkg::PM_IDLE);
      end
   end

   // interrupt pending, a new event beats the acknowledge
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_pending <= 1'b0;
      else if (cmd_done || err_det)
         irq_pending <= 1'b1;
      else if (stat_rd || state == ST_APPLY)
         irq_pending <= 1'b0;
   end

   assign intrq = irq_pending && !irq_mask_q && dev_selected;

   // ready
   always_ff @(posedge clk)
   begin
      if (rst)
         ready_q <= 1'b0;
      else if (err_det)
         ready_q <= 1'b0;
      else if (state == ST_POR_DIAG && diag_done)
         ready_q <= 1'b1;
      else if (stat_rd || state == ST_APPLY)
         ready_q <= 1'b1;
   end

   // error hold freezes seek-done until status is read
   always_ff @(posedge clk)
   begin
      if (rst)
         err_hold <= 1'b0;
      else if (err_det)
         err_hold <= 1'b1;
      else if (stat_rd || state == ST_APPLY)
         err_hold <= 1'b0;
   end

   // actual seek-complete state
   always_ff @(posedge clk)
   begin
      if (rst)
         seek_q <= 1'b1;
      else if (seek_start)
         seek_q <= 1'b0;
      else if (seek_settled)
         seek_q <= 1'b1;
   end

   // fail bit
   always_ff @(posedge clk)
   begin
      if (rst)
         fail_q <= 1'b0;
      else if (err_det)
         fail_q <= 1'b1;
      else if (cmd_wr || state == ST_APPLY)
         fail_q <= 1'b0;
   end

   // status register refreshed every cycle except seek-done on an error cycle and under error hold outside standby and sleep, so errors and completions show at once
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status <= asr_pkg::STATUS_RESET;
      end
      else
      begin
         status.busy       <= (next_state != ST_RUN) || reg_access || comreset;
         status.ready      <= (err_det ? 1'b0 : ready_q) && (next_state == ST_RUN);
         status.fault      <= 1'b0;
         if (low_power)
            status.seek_done <= 1'b1;
         else if (!err_hold && !err_det)
            status.seek_done <= seek_start ? 1'b0 : (seek_settled | seek_q);
         status.xfer_req   <= xfer_ready && (next_state == ST_RUN);
         status.fixed_data <= 1'b0;
         status.rev_mark   <= rev_mark;
         status.fail       <= err_det || (fail_q && !cmd_wr);
      end
   end

   // register read port
   always_ff @(posedge clk)
   begin
      if (rst)
         rd_data <= asr_pkg::STATUS_RESET;
      else if (reg_rd)
      begin
         if (busy)
            rd_data <= status;
         else
            case (reg_sel)
               asr_pkg::SEL_STATUS:
                  rd_data <= status;
               asr_pkg::SEL_ALT_STATUS:
                  rd_data <= status;
               asr_pkg::SEL_ERROR:
                  rd_data <= tf_defaults.error;
               default:
                  rd_data <= 8'h00;
            endcase
      end
   end

endmodule

// ==== testbench/asr_status_reset_assertions.sv ====
// concurrent checks on the status and reset block ports
`timescale 1ns/10ps
module asr_status_reset_assertions #(
   parameter int unsigned REV_PERIOD  = 50,
   parameter int unsigned DIAG_LENGTH = 8
) (
   input wire logic                 clk,           // clock
   input wire logic                 rst,           // reset
   input wire logic                 reg_rd,        // read strobe
   input wire asr_pkg::asr_sel_e    reg_sel,       // read select
   input wire logic [7:0]           rd_data,       // read answer
   input wire logic                 dctl_wr,       // control write
   input wire logic                 cmd_done,      // completion
   input wire logic                 err_det,       // error
   input wire logic                 dev_selected,  // selected
   input wire logic                 cache_flushed, // cache on media
   input wire logic                 intrq,         // interrupt
   input wire asr_pkg::asr_status_s status,        // status
   input wire asr_pkg::asr_tf_s     tf_defaults,   // defaults
   input wire logic                 tf_load,       // load pulse
   input wire logic                 abort_host,    // host abort
   input wire logic                 abort_dev,     // device abort
   input wire logic                 iface_reset,   // interface reset
   input wire logic                 hw_init        // hardware init
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] since_rst;
   always_ff @(posedge clk)
   begin
      if (rst)
         since_rst <= 3'h0;
      else if (since_rst != 3'h7)
         since_rst <= since_rst + 3'h1;
   end
   sequence por_release;
      $fell(rst) ##3 1'b1;
   endsequence
   sequence clean_status_read;
      reg_rd && reg_sel == asr_pkg::SEL_STATUS && !status.busy && !err_det && !cmd_done;
   endsequence
   sequence alt_read_pending;
      reg_rd && reg_sel == asr_pkg::SEL_ALT_STATUS && intrq && !dctl_wr ##1 dev_selected;
   endsequence
   fixed_zero_a: assert property (!status.fault && !status.fixed_data)
      else $error("fault or fixed bit set");
   por_ready_a: assert property (por_release |-> !status.ready [*3])
      else $error("ready early after power-up");
   intrq_gate_a: assert property (intrq |-> dev_selected)
      else $error("interrupt while unselected");
   busy_read_a: assert property (reg_rd && status.busy |=> rd_data[7])
      else $error("busy read not status");
   read_ack_a: assert property (clean_status_read |=> !intrq)
      else $error("status read kept interrupt");
   alt_noack_a: assert property (alt_read_pending |-> intrq)
      else $error("alternate read cleared interrupt");
   tf_default_a: assert property (tf_load |-> tf_defaults[39:0] == 40'h0101000000)
      else $error("bad task-file defaults");
   diag_code_a: assert property (tf_load |-> tf_defaults.error inside {[8'h01:8'h05]})
      else $error("bad diagnostic code");
   abort_flush_a: assert property (abort_dev |-> $past(cache_flushed, 2))
      else $error("abort before cache flush");
   abort_pair_a: assert property (abort_host |-> abort_dev && iface_reset)
      else $error("abort without interface reset");
   hw_init_por_a: assert property (hw_init |-> since_rst < 3'h4)
      else $error("hardware init outside power-up");
endmodule
bind asr_status_reset asr_status_reset_assertions #(.REV_PERIOD(REV_PERIOD),
   .DIAG_LENGTH(DIAG_LENGTH)) asr_status_reset_assertions_inst (.clk(clk), .rst(rst),
   .reg_rd(reg_rd), .reg_sel(reg_sel), .rd_data(rd_data), .dctl_wr(dctl_wr),
   .cmd_done(cmd_done), .err_det(err_det), .dev_selected(dev_selected),
   .cache_flushed(cache_flushed), .intrq(intrq), .status(status),
   .tf_defaults(tf_defaults), .tf_load(tf_load), .abort_host(abort_host),
   .abort_dev(abort_dev), .iface_reset(iface_reset), .hw_init(hw_init));

// ==== testbench/asr_host_model.sv ====
// host adapter model issuing shadow register traffic
`timescale 1ns/10ps
module asr_host_model (
   input  wire logic                 clk,            // clock
   input  wire asr_pkg::asr_status_s status,         // device status
   input  wire logic [7:0]           rd_data,        // read answer
   output logic                      reg_rd,         // read strobe
   output asr_pkg::asr_sel_e         reg_sel,        // read select
   output logic                      dctl_wr,        // control write
   output logic                      soft_reset_bit, // soft reset data
   output logic                      irq_mask_bit,   // mask data
   output logic                      cmd_wr          // command write
);
   initial
   begin
      reg_rd = 1'b0;
      reg_sel = asr_pkg::SEL_OTHER;
      dctl_wr = 1'b0;
      soft_reset_bit = 1'b0;
      irq_mask_bit = 1'b0;
      cmd_wr = 1'b0;
   end
   task automatic rd(input asr_pkg::asr_sel_e sel, input bit polite, output logic [7:0] d);
      for (int n = 0; polite && status.busy !== 1'b0 && n < 100; n++)
         @(negedge clk);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_sel = sel;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = rd_data;
   endtask
   task automatic dctl(input logic set_bit, input logic mask);
      @(negedge clk);
      dctl_wr = 1'b1;
      soft_reset_bit = set_bit;
      irq_mask_bit = mask;
      @(negedge clk);
      dctl_wr = 1'b0;
   endtask
   task automatic soft_reset();
      dctl(1'b1, 1'b0);
      repeat (1000) @(negedge clk);
      dctl(1'b0, 1'b0);
   endtask
   task automatic cmd();
      for (int n = 0; status.xfer_req !== 1'b0 && n < 100; n++)
         @(negedge clk);
      @(negedge clk);
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
   endtask
endmodule

// ==== testbench/asr_status_reset_tb.sv ====
// self-checking bench of the status and reset block
`timescale 1ns/10ps
module asr_status_reset_tb;
   typedef struct {asr_pkg::asr_sel_e sel; logic [7:0] exp;} asr_row_s;
   logic clk, rst, reg_rd, dctl_wr, soft_reset_bit, irq_mask_bit, cmd_wr, feat_wr;
   logic dev_selected, reg_access, cmd_done, err_det, seek_start, seek_settled;
   logic xfer_ready, pm_req, timer_set, comreset, cache_flushed, pus_enable, intrq;
   logic tf_load, iface_reset, abort_host, abort_dev, hw_init, param_restore;
   logic spin_up, stby_timer_en;
   logic [7:0] feat_code, rd_data, d;
   logic [3:0] diag_fail;
   logic [5:0] seen;
   asr_pkg::asr_sel_e reg_sel;
   asr_pkg::asr_pm_e pm_target, power_mode;
   asr_pkg::asr_status_s status;
   asr_pkg::asr_tf_s tf_defaults;
   int err_count, n_checks, cycles;
   asr_row_s rows[4] = '{'{asr_pkg::SEL_STATUS, 8'h50}, '{asr_pkg::SEL_ALT_STATUS, 8'h50},
                         '{asr_pkg::SEL_ERROR, 8'h01}, '{asr_pkg::SEL_OTHER, 8'h00}};
   asr_status_reset #(.REV_PERIOD(50), .DIAG_LENGTH(8)) asr_status_reset_inst (.clk(clk),
      .rst(rst), .reg_rd(reg_rd), .reg_sel(reg_sel), .rd_data(rd_data), .dctl_wr(dctl_wr),
      .soft_reset_bit(soft_reset_bit), .irq_mask_bit(irq_mask_bit), .cmd_wr(cmd_wr),
      .feat_wr(feat_wr), .feat_code(feat_code), .dev_selected(dev_selected),
      .reg_access(reg_access), .cmd_done(cmd_done), .err_det(err_det),
      .seek_start(seek_start), .seek_settled(seek_settled), .xfer_ready(xfer_ready),
      .pm_req(pm_req), .pm_target(pm_target), .timer_set(timer_set), .comreset(comreset),
      .cache_flushed(cache_flushed), .pus_enable(pus_enable), .diag_fail(diag_fail),
      .intrq(intrq), .status(status), .tf_defaults(tf_defaults), .tf_load(tf_load),
      .iface_reset(iface_reset), .abort_host(abort_host), .abort_dev(abort_dev),
      .hw_init(hw_init), .param_restore(param_restore), .spin_up(spin_up),
      .stby_timer_en(stby_timer_en), .power_mode(power_mode));
   asr_host_model asr_host_model_inst (.clk(clk), .status(status), .rd_data(rd_data),
      .reg_rd(reg_rd), .reg_sel(reg_sel), .dctl_wr(dctl_wr), .soft_reset_bit(soft_reset_bit),
      .irq_mask_bit(irq_mask_bit), .cmd_wr(cmd_wr));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      seen = seen | {abort_host, abort_dev, iface_reset, tf_load, param_restore, hw_init};
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s seen %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic wait_idle();
      repeat (4) @(negedge clk);
      for (int n = 0; status.busy !== 1'b0 && n < 3000; n++)
         @(negedge clk);
   endtask
   task automatic por(input logic pus, input logic [3:0] fail);
      pus_enable = pus;
      diag_fail = fail;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      seen = 6'h0;
      rst = 1'b0;
      wait_idle();
   endtask
   initial
   begin
      {dev_selected, cache_flushed} = 2'b10;
      {reg_access, cmd_done, err_det, seek_start, seek_settled, xfer_ready} = 6'h0;
      {pm_req, timer_set, comreset, feat_wr} = 4'h0;
      feat_code = 8'h00;
      pm_target = asr_pkg::PM_IDLE;
      por(1'b0, 4'h0);
      chk({5'h0, seen[0], spin_up, stby_timer_en}, 8'h06, "por outputs");
      chk({6'h0, power_mode}, {6'h0, asr_pkg::PM_IDLE}, "por mode");
      foreach (rows[i])
      begin
         asr_host_model_inst.rd(rows[i].sel, 1'b1, d);
         chk(d & 8'hfd, rows[i].exp, "register default");
      end
      for (int i = 0; i < 60 && status.rev_mark !== 1'b1; i++)
         @(negedge clk);
      chk({7'h0, status.rev_mark}, 8'h01, "revolution mark");
      xfer_ready = 1'b1;
      repeat (2) @(negedge clk);
      chk({7'h0, status.xfer_req}, 8'h01, "transfer request");
      xfer_ready = 1'b0;
      pulse(seek_start);
      chk({7'h0, status.seek_done}, 8'h00, "seek start");
      pulse(seek_settled);
      chk({7'h0, status.seek_done}, 8'h01, "seek settled");
      pulse(err_det);
      pulse(seek_start);
      chk({4'h0, intrq, status.ready, status.seek_done, status.fail}, 8'h0b,
          "after error");
      asr_host_model_inst.rd(asr_pkg::SEL_ALT_STATUS, 1'b1, d);
      chk({7'h0, intrq}, 8'h01, "alternate read");
      asr_host_model_inst.rd(asr_pkg::SEL_STATUS, 1'b1, d);
      chk({5'h0, intrq, status.ready, status.seek_done}, 8'h02, "status read");
      pulse(seek_settled);
      asr_host_model_inst.cmd();
      pulse(cmd_done);
      chk({status & 8'hfd} | {7'h0, intrq}, 8'h51, "completion");
      asr_host_model_inst.dctl(1'b0, 1'b1);
      chk({7'h0, intrq}, 8'h00, "masked");
      asr_host_model_inst.dctl(1'b0, 1'b0);
      dev_selected = 1'b0;
      @(negedge clk);
      chk({7'h0, intrq}, 8'h00, "unselected");
      dev_selected = 1'b1;
      asr_host_model_inst.rd(asr_pkg::SEL_STATUS, 1'b1, d);
      reg_access = 1'b1;
      asr_host_model_inst.rd(asr_pkg::SEL_ERROR, 1'b0, d);
      chk({7'h0, d[7]}, 8'h01, "read while busy");
      reg_access = 1'b0;
      pm_target = asr_pkg::PM_SLEEP;
      pulse(pm_req);
      {seen, cache_flushed} = 7'h0;
      asr_host_model_inst.soft_reset();
      repeat (10) @(negedge clk);
      chk({2'h0, seen}, 8'h00, "abort before flush");
      cache_flushed = 1'b1;
      wait_idle();
      chk({2'h0, seen}, 8'h3c, "soft reset actions");
      chk({6'h0, power_mode}, {6'h0, asr_pkg::PM_STANDBY}, "sleep left");
      feat_code = 8'hcc;
      pulse(feat_wr);
      pulse(timer_set);
      seen = 6'h0;
      pulse(comreset);
      wait_idle();
      chk({2'h0, seen}, 8'h3e, "link reset actions");
      chk({4'h0, stby_timer_en, power_mode, status.seek_done}, 8'h0d, "standby");
      for (int i = 0; i < 4; i++)
      begin
         por(1'b1, 4'h1 << i);
         asr_host_model_inst.rd(asr_pkg::SEL_ERROR, 1'b1, d);
         chk(d, 8'h02 + 8'(i), "diagnostic code");
         chk({4'h0, spin_up, stby_timer_en, power_mode}, 8'h02, "standby power-up");
      end
      tally_and_finish();
   end
endmodule
